// ### rgb_rgmii_bridge.sv
// Top of the RGMII bridge: pad ownership, transmit serialiser, clock
// generation with edge delay, receive path and management pins.
// Assumes tile ports and control bits are on clk_i; pads come from outside.
`timescale 1ns/10ps

// Summary of operation
// - Enable hands dedicated pins to the bridge
// - Signalling follows RGMII 1.3 conventions
// - Convert double-rate nibbles to single-rate bytes
// - Bridge generates transmit clock at selected rate
// - Selectable delay on transmit clock edge
// - Byte side faces fixed tile ports
// - Enabled bridge owns its tile ports exclusively
// - Other pins keep their normal function
// - Separate timing for tx, rx, delay, mode
// - Speed changes on falling edge of valid
// - Management lines are open-drain outputs
module rgb_rgmii_bridge (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control from the processor status bits
  input wire logic rgmii_en_i,
  input wire logic [1:0] speed_sel_i,
  input wire logic [rgb_pkg::DLY_W-1:0] clk_dly_i,
  input wire logic phy_release_i,
  // Tile transmit port
  input wire logic [7:0] tx_byte_path_i,
  input wire logic tx_en_i,
  input wire logic tx_er_i,
  output logic tx_take_o,
  // Tile receive port
  output logic [7:0] rx_byte_path_o,
  output logic rx_dv_o,
  output logic rx_er_o,
  output logic rx_stb_o,
  // General purpose view of the dedicated pads
  input wire logic [rgb_pkg::PAD_N-1:0] gpio_out_i,
  input wire logic [rgb_pkg::PAD_N-1:0] gpio_oe_i,
  output logic [rgb_pkg::PAD_N-1:0] gpio_in_o,
  // Dedicated pads
  input wire logic [rgb_pkg::PAD_N-1:0] pad_i,
  output logic [rgb_pkg::PAD_N-1:0] pad_o,
  output logic [rgb_pkg::PAD_N-1:0] pad_oe_o,
  // Management tile ports
  input wire logic smi_clk_i,
  input wire logic smi_dat_i,
  output logic smi_dat_in_o,
  // Management pads, open drain
  input wire logic smi_dat_pad_i,
  output logic smi_clk_pad_o,
  output logic smi_clk_pad_oe_o,
  output logic smi_dat_pad_o,
  output logic smi_dat_pad_oe_o,
  // PHY reset pin
  output logic phy_rst_n_o
);

  localparam int unsigned SN = rgb_pkg::PAD_N + 1;

  // Pads owned by the bridge when enabled
  localparam logic [rgb_pkg::PAD_N-1:0] OWN_MASK = 12'hFFF;
  // Pads driven by the bridge when enabled (transmit group)
  localparam logic [rgb_pkg::PAD_N-1:0] DRV_MASK = 12'h03F;

  logic en_r;
  rgb_pkg::rgb_speed_t speed_r;
  rgb_pkg::rgb_tx_st_t st_r;
  rgb_pkg::rgb_tx_st_t st_nxt;
  logic [rgb_pkg::HALF_W-1:0] cnt_r;
  logic [rgb_pkg::HALF_W-1:0] half;
  logic cnt_done;
  logic [7:0] txb_r;
  logic txen_r;
  logic txer_r;
  logic txen_prev_r;
  logic mode_tick;
  logic [3:0] nib;
  logic ctl;
  logic [rgb_pkg::DLY_N-2:0] dly_r;
  logic [rgb_pkg::DLY_N-1:0] txc_tap;
  logic txc_dly;
  logic [SN-1:0] sync_q;
  logic [rgb_pkg::PAD_N-1:0] pad_s;
  logic [rgb_pkg::PAD_N-1:0] drv;
  logic [rgb_pkg::PAD_N-1:0] drv_oe;
  rgb_byte_if rxb ();

  // Enable is same-domain logic, one register stage only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_r <= 1'b0;
    end else begin
      en_r <= rgmii_en_i;
    end
  end

  // Falling edge of transmit valid marks a safe point to change speed
  assign mode_tick = txen_prev_r & ~txen_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txen_prev_r <= 1'b0;
    end else begin
      txen_prev_r <= txen_r;
    end
  end

  // Speed follows the request only between frames, never mid-frame
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      speed_r <= rgb_pkg::SPEED_RST;
    end else if (!en_r || mode_tick) begin
      unique case (speed_sel_i)
        2'b00: speed_r <= rgb_pkg::SPD_10;
        2'b01: speed_r <= rgb_pkg::SPD_100;
        default: speed_r <= rgb_pkg::SPD_1000;
      endcase
    end
  end

  // Half period of the generated clock at the current speed
  always_comb begin
    unique case (speed_r)
      rgb_pkg::SPD_10: half = rgb_pkg::HALF_10;
      rgb_pkg::SPD_100: half = rgb_pkg::HALF_100;
      rgb_pkg::SPD_1000: half = rgb_pkg::HALF_1000;
      default: half = rgb_pkg::HALF_1000;
    endcase
  end

  assign cnt_done = (cnt_r == '0);

  // Phase sequencer: rising half then falling half, forever while enabled
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      rgb_pkg::TXS_OFF: begin
        if (en_r) begin
          st_nxt = rgb_pkg::TXS_RISE;
        end
      end
      rgb_pkg::TXS_RISE: begin
        if (cnt_done) begin
          st_nxt = rgb_pkg::TXS_FALL;
        end
      end
      rgb_pkg::TXS_FALL: begin
        if (cnt_done) begin
          st_nxt = rgb_pkg::TXS_RISE;
        end
      end
      default: st_nxt = rgb_pkg::TXS_OFF;
    endcase
    if (!en_r) begin
      st_nxt = rgb_pkg::TXS_OFF;
    end
  end

  // Transmit path timing: state and half period counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= rgb_pkg::TXS_OFF;
      cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        cnt_r <= half - 8'h01;
      end else if (!cnt_done) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  // Byte taken from the tile at each rising half
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txb_r <= 8'h00;
      txen_r <= 1'b0;
      txer_r <= 1'b0;
      tx_take_o <= 1'b0;
    end else begin
      tx_take_o <= 1'b0;
      if (!en_r) begin
        txen_r <= 1'b0;
        txer_r <= 1'b0;
      end else if (st_nxt == rgb_pkg::TXS_RISE && st_r != rgb_pkg::TXS_RISE) begin
        txb_r <= tx_byte_path_i;
        txen_r <= tx_en_i;
        txer_r <= tx_er_i;
        tx_take_o <= 1'b1;
      end
    end
  end

  // Nibble and control per half: low and valid, then high and valid xor error
  always_comb begin
    nib = txb_r[3:0];
    ctl = txen_r;
    if (st_r == rgb_pkg::TXS_FALL) begin
      nib = txb_r[7:4];
      ctl = txen_r ^ txer_r;
    end
  end

  // Delay line for the clock edge; costs up to three cycles of skew
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly_r <= '0;
    end else begin
      dly_r <= {dly_r[rgb_pkg::DLY_N-3:0], (st_r == rgb_pkg::TXS_RISE)};
    end
  end

  // Tap 0 is the undelayed phase, so delay zero keeps the edge on the data
  assign txc_tap = {dly_r, (st_r == rgb_pkg::TXS_RISE)};
  assign txc_dly = txc_tap[clk_dly_i];

  // Pad values the bridge drives on its transmit group
  always_comb begin
    drv = '0;
    drv[rgb_pkg::PAD_TXD0:rgb_pkg::PAD_TXD3] = {nib[0], nib[1], nib[2], nib[3]};
    drv[rgb_pkg::PAD_TXC] = txc_dly;
    drv[rgb_pkg::PAD_TXCTL] = ctl;
    drv_oe = DRV_MASK;
  end

  // Pad mux: bridge owns its pads when enabled, else general purpose
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pad_o <= '0;
      pad_oe_o <= '0;
    end else if (en_r) begin
      pad_o <= (drv & OWN_MASK) | (gpio_out_i & ~OWN_MASK);
      pad_oe_o <= (drv_oe & OWN_MASK) | (gpio_oe_i & ~OWN_MASK);
    end else begin
      pad_o <= gpio_out_i;
      pad_oe_o <= gpio_oe_i;
    end
  end

  // All pad inputs and the management data pad input cross from outside the clock domain
  rgb_sync #(
    .W(SN)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({smi_dat_pad_i, pad_i}),
    .q_o(sync_q)
  );

  assign pad_s = sync_q[rgb_pkg::PAD_N-1:0];

  // General purpose read of owned pads returns zero while enabled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gpio_in_o <= '0;
    end else begin
      gpio_in_o <= en_r ? (pad_s & ~OWN_MASK) : pad_s;
    end
  end

  // Receive deserialiser
  rgb_rx_deser u_rx (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .en_i(en_r),
    .rxc_i(pad_s[rgb_pkg::PAD_RXC]),
    .rxctl_i(pad_s[rgb_pkg::PAD_RXCTL]),
    .rxd_i(pad_s[rgb_pkg::PAD_RXD3:rgb_pkg::PAD_RXD0]),
    .byte_o(rxb.src)
  );

  // Receive byte to the tile port; the strobe is a one-cycle pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_byte_path_o <= 8'h00;
      rx_dv_o <= 1'b0;
      rx_er_o <= 1'b0;
      rx_stb_o <= 1'b0;
    end else begin
      rx_stb_o <= rxb.stb & en_r;
      if (rxb.stb && en_r) begin
        rx_byte_path_o <= rxb.data;
        rx_dv_o <= rxb.dv;
        rx_er_o <= rxb.er;
      end
    end
  end

  // Management lines: only ever pull low, pull-ups make the high level
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      smi_clk_pad_o <= 1'b0;
      smi_clk_pad_oe_o <= 1'b0;
      smi_dat_pad_o <= 1'b0;
      smi_dat_pad_oe_o <= 1'b0;
      smi_dat_in_o <= 1'b1;
    end else begin
      smi_clk_pad_oe_o <= ~smi_clk_i;
      smi_dat_pad_oe_o <= ~smi_dat_i;
      smi_dat_in_o <= sync_q[SN-1];
    end
  end

  // PHY stays in reset until enabled and released, keeping its clock quiet
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phy_rst_n_o <= 1'b0;
    end else begin
      phy_rst_n_o <= en_r & phy_release_i;
    end
  end

endmodule : rgb_rgmii_bridge

// ### rgb_pkg.sv
// Shared constants and types for the RGMII double-rate to single-rate bridge.
// Assumes a single 40 MHz system clock; all link timing is scaled onto it.
package rgb_pkg;

  // System clock
  localparam int unsigned CLK_NS = 25;

  // Nominal link clock periods per speed, in ns
  localparam int unsigned PER_1000_NS = 8;
  localparam int unsigned PER_100_NS = 40;
  localparam int unsigned PER_10_NS = 400;

  // Half period in system cycles, rounded down, never below one cycle
  function automatic int unsigned half_cyc(input int unsigned per_ns);
    int unsigned c;
    c = per_ns / (2 * CLK_NS);
    return (c < 1) ? 1 : c;
  endfunction : half_cyc

  localparam int unsigned HALF_W = 8;
  localparam logic [HALF_W-1:0] HALF_1000 = HALF_W'(half_cyc(PER_1000_NS));
  localparam logic [HALF_W-1:0] HALF_100 = HALF_W'(half_cyc(PER_100_NS));
  localparam logic [HALF_W-1:0] HALF_10 = HALF_W'(half_cyc(PER_10_NS));

  // Line speed
  typedef enum logic [1:0] {
    SPD_10 = 2'b00,
    SPD_100 = 2'b01,
    SPD_1000 = 2'b10
  } rgb_speed_t;
  localparam rgb_speed_t SPEED_RST = SPD_1000;

  // Transmit phase sequencer
  typedef enum logic [1:0] {
    TXS_OFF = 2'b00,
    TXS_RISE = 2'b01,
    TXS_FALL = 2'b10
  } rgb_tx_st_t;

  // Dedicated pad positions
  localparam int unsigned PAD_N = 12;
  localparam int unsigned PAD_TXD3 = 0;
  localparam int unsigned PAD_TXD0 = 3;
  localparam int unsigned PAD_TXC = 4;
  localparam int unsigned PAD_TXCTL = 5;
  localparam int unsigned PAD_RXC = 6;
  localparam int unsigned PAD_RXCTL = 7;
  localparam int unsigned PAD_RXD0 = 8;
  localparam int unsigned PAD_RXD3 = 11;

  // Clock edge delay select width and delay line length
  localparam int unsigned DLY_W = 2;
  localparam int unsigned DLY_N = 4;

endpackage : rgb_pkg

// ### rgb_byte_if.sv
// Byte stream carrier between the receive deserialiser and the bridge top.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface rgb_byte_if;
  logic [7:0] data;
  logic dv;
  logic er;
  logic stb;
  modport src (output data, output dv, output er, output stb);
  modport snk (input data, input dv, input er, input stb);
endinterface : rgb_byte_if

// ### rgb_sync.sv
// Two flip-flop synchroniser for a bus of independent levels.
// Assumes each bit is a slow or oversampled level; no bus coherence is kept.
`timescale 1ns/10ps
module rgb_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Levels
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  // A zero-width bus has nothing to carry
  if (W == 0) begin : g_bad_w
    $error("sync width must be at least one");
  end

  // First stage is read only by the second
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule : rgb_sync

// ### rgb_rx_deser.sv
// Receive side: folds double-rate nibbles and control into bytes.
// Assumes the link clock, control and data were already synchronised together.
`timescale 1ns/10ps
module rgb_rx_deser (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Block enable
  input wire logic en_i,
  // Synchronised link signals
  input wire logic rxc_i,
  input wire logic rxctl_i,
  input wire logic [3:0] rxd_i,
  // Byte output
  rgb_byte_if.src byte_o
);

  logic rxc_prev_r;
  logic lo_ok_r;
  logic [3:0] lo_r;
  logic dv_r;
  logic rise;
  logic fall;

  assign rise = rxc_i & ~rxc_prev_r;
  assign fall = ~rxc_i & rxc_prev_r;

  // Edge detect on the sampled link clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rxc_prev_r <= 1'b0;
    end else begin
      rxc_prev_r <= rxc_i;
    end
  end

  // Rising edge carries low nibble and valid
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lo_r <= 4'h0;
      dv_r <= 1'b0;
      lo_ok_r <= 1'b0;
    end else if (!en_i) begin
      lo_ok_r <= 1'b0;
    end else if (rise) begin
      lo_r <= rxd_i;
      dv_r <= rxctl_i;
      lo_ok_r <= 1'b1;
    end else if (fall) begin
      lo_ok_r <= 1'b0;
    end
  end

  // Falling edge completes the byte; a lone falling edge is dropped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_o.data <= 8'h00;
      byte_o.dv <= 1'b0;
      byte_o.er <= 1'b0;
      byte_o.stb <= 1'b0;
    end else begin
      byte_o.stb <= 1'b0;
      if (en_i && fall && lo_ok_r) begin
        byte_o.data <= {rxd_i, lo_r};
        byte_o.dv <= dv_r;
        byte_o.er <= dv_r ^ rxctl_i;
        byte_o.stb <= 1'b1;
      end
    end
  end

endmodule : rgb_rx_deser

// ### rgb_phy_model.sv
// Behavioural PHY receive side for the bridge bench.
// Assumes the bench resolves pad levels from these outputs.
`timescale 1ns/10ps
module rgb_phy_model (
  // Clock and PHY reset
  input wire logic clk_i,
  input wire logic phy_rst_n_i,
  // Receive pins
  output logic rxc_o,
  output logic rxctl_o,
  output logic [3:0] rxd_o
);
  // Clock idles low, so no false edge appears between frames
  initial begin
    rxc_o = 1'b0;
    rxctl_o = 1'b0;
    rxd_o = 4'hA;
  end
  // One byte, each half held h cycles
  task automatic send(input logic [7:0] b, input logic dv, input logic er, input int h);
    if (phy_rst_n_i !== 1'b1) return;
    @(posedge clk_i);
    #2;
    rxc_o = 1'b1;
    rxd_o = b[3:0];
    rxctl_o = dv;
    repeat (h) @(posedge clk_i);
    #2;
    rxc_o = 1'b0;
    rxd_o = b[7:4];
    rxctl_o = dv ^ er;
    repeat (h) @(posedge clk_i);
    #2;
    // Stale data would hide a late capture, so flip it
    rxd_o = ~rxd_o;
    rxctl_o = 1'b0;
  endtask : send
endmodule : rgb_phy_model

// ### rgb_bridge_checker.sv
// Port assertions for the RGMII bridge top.
// Assumes one clock and an async active-low reset.
`timescale 1ns/10ps
module rgb_bridge_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic rgmii_en_i,
  input wire logic phy_release_i,
  input wire logic [7:0] tx_byte_path_i,
  input wire logic tx_en_i,
  input wire logic tx_take_o,
  input wire logic [rgb_pkg::PAD_N-1:0] gpio_in_o,
  input wire logic [rgb_pkg::PAD_N-1:0] pad_o,
  input wire logic [rgb_pkg::PAD_N-1:0] pad_oe_o,
  input wire logic smi_clk_i,
  input wire logic smi_dat_i,
  input wire logic smi_clk_pad_o,
  input wire logic smi_clk_pad_oe_o,
  input wire logic smi_dat_pad_o,
  input wire logic smi_dat_pad_oe_o,
  input wire logic phy_rst_n_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Low nibble in pad order (TXD3 at index 0) and valid, two edges back,
  // since the pad shows a taken byte one cycle after the take pulse
  logic [3:0] lo_r;
  logic [3:0] lo_q_r;
  logic en_r;
  logic en_q_r;
  always_ff @(posedge clk_i) begin
    lo_r <= {tx_byte_path_i[0], tx_byte_path_i[1], tx_byte_path_i[2], tx_byte_path_i[3]};
    en_r <= tx_en_i;
    lo_q_r <= lo_r;
    en_q_r <= en_r;
  end
  property p_pad_own;
    rgmii_en_i [*3] |-> pad_oe_o == 12'h03F;
  endproperty
  a_pad_own: assert property (p_pad_own) else $error("pads not owned");
  property p_gpio_mask;
    rgmii_en_i [*5] |-> gpio_in_o == 12'h000;
  endproperty
  a_gpio_mask: assert property (p_gpio_mask) else $error("gpio sees pads");
  property p_phy_rst;
    $past(rst_n_i) |-> phy_rst_n_o == ($past(rgmii_en_i, 2) && $past(phy_release_i));
  endproperty
  a_phy_rst: assert property (p_phy_rst) else $error("phy reset wrong");
  property p_smi_oe;
    $past(rst_n_i) |-> smi_clk_pad_oe_o == !$past(smi_clk_i) && smi_dat_pad_oe_o == !$past(smi_dat_i);
  endproperty
  a_smi_oe: assert property (p_smi_oe) else $error("smi enable wrong");
  property p_smi_low;
    smi_clk_pad_o == 1'b0 && smi_dat_pad_o == 1'b0;
  endproperty
  a_smi_low: assert property (p_smi_low) else $error("smi drives high");
  property p_take_gap;
    tx_take_o |=> !tx_take_o;
  endproperty
  a_take_gap: assert property (p_take_gap) else $error("take too close");
  property p_take_off;
    !rgmii_en_i [*4] |-> !tx_take_o;
  endproperty
  a_take_off: assert property (p_take_off) else $error("take while off");
  property p_tx_lo;
    tx_take_o |=> pad_o[3:0] == lo_q_r && pad_o[5] == en_q_r;
  endproperty
  a_tx_lo: assert property (p_tx_lo) else $error("tx low half wrong");
endmodule : rgb_bridge_checker
bind rgb_rgmii_bridge rgb_bridge_checker rgb_bridge_checker_i (.clk_i, .rst_n_i, .rgmii_en_i,
  .phy_release_i, .tx_byte_path_i, .tx_en_i, .tx_take_o, .gpio_in_o, .pad_o, .pad_oe_o,
  .smi_clk_i, .smi_dat_i, .smi_clk_pad_o, .smi_clk_pad_oe_o, .smi_dat_pad_o,
  .smi_dat_pad_oe_o, .phy_rst_n_o);

// ### tb_top.sv
// Self-checking bench for the RGMII bridge.
// Assumes the checker binds itself; pad levels are resolved here.
`timescale 1ns/10ps
module tb_top;
  logic clk_i, rst_n_i, rgmii_en_i, phy_release_i, tx_en_i, tx_er_i, tx_take_o;
  logic [1:0] speed_sel_i;
  logic [rgb_pkg::DLY_W-1:0] clk_dly_i;
  logic [7:0] tx_byte_path_i, rx_byte_path_o;
  logic rx_dv_o, rx_er_o, rx_stb_o, rxc, rxctl;
  logic [3:0] rxd;
  logic [rgb_pkg::PAD_N-1:0] gpio_out_i, gpio_oe_i, gpio_in_o, pad_i, pad_o, pad_oe_o;
  logic smi_clk_i, smi_dat_i, smi_dat_in_o, smi_dat_pad_i, phy_rst_n_o;
  logic smi_clk_pad_o, smi_clk_pad_oe_o, smi_dat_pad_o, smi_dat_pad_oe_o;
  int n_fail = 0;
  int comparisons = 0;
  int k;
  int n_stb = 0;
  // Receive strobes counted mid-cycle, where the pulse has settled
  always @(negedge clk_i) begin
    if (rx_stb_o === 1'b1) begin
      n_stb++;
    end
  end
  // Driven pads win; undriven tx pads show a fixed odd pattern
  assign pad_i = (pad_oe_o & pad_o) | (~pad_oe_o & {rxd, rxctl, rxc, 6'h2A});
  // Pull-up on the management data line
  assign smi_dat_pad_i = ~smi_dat_pad_oe_o;
  rgb_rgmii_bridge rgb_rgmii_bridge_i (.clk_i, .rst_n_i, .rgmii_en_i, .speed_sel_i, .clk_dly_i,
    .phy_release_i, .tx_byte_path_i, .tx_en_i, .tx_er_i, .tx_take_o, .rx_byte_path_o, .rx_dv_o,
    .rx_er_o, .rx_stb_o, .gpio_out_i, .gpio_oe_i, .gpio_in_o, .pad_i, .pad_o, .pad_oe_o,
    .smi_clk_i, .smi_dat_i, .smi_dat_in_o, .smi_dat_pad_i, .smi_clk_pad_o, .smi_clk_pad_oe_o,
    .smi_dat_pad_o, .smi_dat_pad_oe_o, .phy_rst_n_o);
  rgb_phy_model rgb_phy_model_i (.clk_i, .phy_rst_n_i(phy_rst_n_o), .rxc_o(rxc),
    .rxctl_o(rxctl), .rxd_o(rxd));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  // Inputs move 2 ns after an edge, outputs are read there too
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : cyc
  // k counts cycles to the next take pulse
  task automatic wait_take;
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (tx_take_o !== 1'b1 && k < 40);
    chk(tx_take_o, "no take pulse");
  endtask : wait_take
  task automatic end_sim;
    $display("%0d mismatches in %0d comparisons", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim
  task automatic test_pads;
    gpio_out_i = 12'h5A5;
    gpio_oe_i = 12'hFFF;
    cyc(6);
    chk(pad_oe_o === 12'hFFF && pad_o === 12'h5A5, "gpio drive");
    chk(gpio_in_o === 12'h5A5, "gpio read");
    rgmii_en_i = 1'b1;
    cyc(6);
    chk(pad_oe_o === 12'h03F, "pad owner");
    chk(gpio_in_o === 12'h000, "gpio masked");
    $display("test_pads done");
  endtask : test_pads
  task automatic test_phy;
    chk(phy_rst_n_o === 1'b0, "phy out of reset");
    phy_release_i = 1'b1;
    cyc(3);
    chk(phy_rst_n_o === 1'b1, "phy held");
    $display("test_phy done");
  endtask : test_phy
  // Table entries are {valid, error, byte}
  task automatic test_rx;
    logic [9:0] tbl [3] = '{10'h25A, 10'h3C3, 10'h100};
    int s;
    for (int i = 0; i < 3; i++) begin
      s = n_stb;
      rgb_phy_model_i.send(tbl[i][7:0], tbl[i][9], tbl[i][8], 4);
      cyc(8);
      chk(n_stb == s + 1, "rx strobe count");
      chk(rx_byte_path_o === tbl[i][7:0], "rx byte");
      chk(rx_dv_o === tbl[i][9] && rx_er_o === tbl[i][8], "rx control");
    end
    $display("test_rx done");
  endtask : test_rx
  // Byte C1 lands as pads 8 then 3; control 1 then 1^1; clock 1 then 0
  task automatic test_tx;
    tx_en_i = 1'b1;
    tx_er_i = 1'b1;
    wait_take();
    cyc(1);
    chk(pad_o[5:0] === 6'h38, "tx rising half");
    cyc(1);
    chk(pad_o[5:0] === 6'h03, "tx falling half");
    tx_er_i = 1'b0;
    $display("test_tx done");
  endtask : test_tx
  task automatic test_speed;
    speed_sel_i = 2'b00;
    wait_take();
    wait_take();
    chk(k == 2, "speed moved while valid");
    tx_en_i = 1'b0;
    cyc(6);
    tx_en_i = 1'b1;
    wait_take();
    wait_take();
    chk(k == 16, "slow period");
    for (int d = 0; d < 4; d++) begin
      clk_dly_i = 2'(d);
      wait_take();
      wait_take();
      cyc(1);
      k = 0;
      while (pad_o[rgb_pkg::PAD_TXC] !== 1'b1 && k < 10) begin
        cyc(1);
        k++;
      end
      chk(k == d, "clock edge delay");
    end
    tx_en_i = 1'b0;
    speed_sel_i = 2'b01;
    cyc(40);
    tx_en_i = 1'b1;
    wait_take();
    wait_take();
    chk(k == 2, "mid speed period");
    $display("test_speed done");
  endtask : test_speed
  task automatic test_smi;
    smi_clk_i = 1'b0;
    smi_dat_i = 1'b0;
    cyc(5);
    chk(smi_dat_in_o === 1'b0 && smi_clk_pad_oe_o === 1'b1, "smi pull low");
    smi_clk_i = 1'b1;
    smi_dat_i = 1'b1;
    cyc(5);
    chk(smi_dat_in_o === 1'b1 && smi_clk_pad_oe_o === 1'b0, "smi release");
    $display("test_smi done");
  endtask : test_smi
  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    rgmii_en_i = 1'b0;
    speed_sel_i = 2'b10;
    clk_dly_i = 2'h0;
    phy_release_i = 1'b0;
    tx_byte_path_i = 8'hC1;
    tx_en_i = 1'b0;
    tx_er_i = 1'b0;
    gpio_out_i = 12'h000;
    gpio_oe_i = 12'h000;
    smi_clk_i = 1'b1;
    smi_dat_i = 1'b1;
    cyc(2);
    rst_n_i = 1'b1;
    test_pads();
    test_phy();
    test_rx();
    test_tx();
    test_speed();
    test_smi();
    end_sim();
  end
  // Watchdog at roughly ten times the expected run
  initial begin
    #100000;
    n_fail++;
    end_sim();
  end
endmodule : tb_top
